// ===== hdl/gpx_pkg.sv
// Purpose: Shared constants for the general-purpose I/O port with external interrupts.
// Assumes: 8 pins, 2 interrupt vectors of 4 pins each, AXI4-Lite with 32-bit data.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package gpx_pkg;
    localparam int NPINS = 8;
    localparam int NVEC = 2;
    localparam int GRP = 4;
    localparam int AW = 8;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [AW-1:0] OFS_DATA = 8'h00;
    localparam logic [AW-1:0] OFS_DIR = 8'h04;
    localparam logic [AW-1:0] OFS_OPT = 8'h08;
    localparam logic [AW-1:0] OFS_SENS = 8'h0c;
    localparam logic [AW-1:0] OFS_CTRL = 8'h10;
    localparam logic [AW-1:0] OFS_PEND = 8'h14;
    localparam int CTRL_GMASK = 0;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [NPINS-1:0] RST_DATA = 8'h00;
    localparam logic [NPINS-1:0] RST_DIR = 8'h00;
    localparam logic [NPINS-1:0] RST_OPT = 8'h00;
    localparam logic [NVEC-1:0] RST_SENS = 2'h0;
    localparam logic RST_GMASK = 1'b1;
    localparam logic [NPINS-1:0] ALL_ONES = 8'hff;
    localparam logic [NPINS-1:0] ALL_ZERO = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gpx_pkg

// ===== hdl/gpx_port.sv
// Purpose: Eight-pin bidirectional port with pull-up, open-drain, alternate
//          functions and two grouped external interrupt vectors.
// Assumes: Pins 0..3 feed vector 0, pins 4..7 feed vector 1; sens bit 1 = rising.
// Notes:   Pin outputs are registered, so the pin follows a write after two edges.

// How it works
// - Input mode reads synchronised pin level
// - Option bit selects pull-up on inputs
// - Data write on input only updates latch
// - Option on input enables pin interrupt
// - Edge polarity programmable per vector
// - Group pins ANDed into one source
// - Vector fetch clears pending request
// - Sensitivity change clears pending request
// - Disabled pin forces detector input high
// - Output mode drives latch, reads latch
// - Option picks push-pull or open-drain
// - Peripheral output forces pin to output
// - Input plus peripheral output reads peripheral
// - Output mode feeds latch to peripheral
// - Floating input passes level to peripheral
// - Pull-up and high driver per configuration
// - Low-power modes keep state, pending wakes
// - Interrupt only if enabled and unmasked
// - Eight pins, bit x controls pin x
module gpx_port (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [gpx_pkg::AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [gpx_pkg::AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [gpx_pkg::NPINS-1:0] pin_in,
    output logic [gpx_pkg::NPINS-1:0] pin_out,
    output logic [gpx_pkg::NPINS-1:0] pin_oe_b,
    output logic [gpx_pkg::NPINS-1:0] pull_up_en,
    output logic [gpx_pkg::NPINS-1:0] high_drive_en,
    input wire logic [gpx_pkg::NPINS-1:0] alt_out_en,
    input wire logic [gpx_pkg::NPINS-1:0] alt_out_val,
    output logic [gpx_pkg::NPINS-1:0] alt_in,
    input wire logic [gpx_pkg::NVEC-1:0] vector_fetch,
    output logic [gpx_pkg::NVEC-1:0] irq_req,
    output logic wake_req
);
    import gpx_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [NPINS-1:0] pin_data_latch_q, pin_data_latch_d;
    logic [NPINS-1:0] pin_direction_bit_q, pin_direction_bit_d;
    logic [NPINS-1:0] pin_option_bit_q, pin_option_bit_d;
    logic [NVEC-1:0] ext_irq_sensitivity_ctrl_q, ext_irq_sensitivity_ctrl_d;
    logic gmask_q, gmask_d;
    logic [NVEC-1:0] pend_q, pend_d;
    logic [NVEC-1:0] src_prev_q;
    logic [NPINS-1:0] sync1_q, sync2_q;
    logic [NPINS-1:0] pin_out_q, pin_oe_b_q, pull_up_q, high_drive_q, alt_in_q;
    logic [NVEC-1:0] irq_req_q;
    logic wake_q;
    logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
    logic awready_q, wready_q, arready_q;
    logic [AW-1:0] aw_addr_q, ar_addr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;

    // Returns the AND of one vector's group of detector inputs.
    function automatic logic group_level(input logic [NPINS-1:0] det, input int v);
        logic r;
        r = 1'b1;
        for (int i = 0; i < GRP; i++) begin
            r = r & det[v*GRP+i];
        end
        return r;
    endfunction : group_level

    // Tells whether an address is one of the mapped words.
    function automatic logic addr_mapped(input logic [AW-1:0] a);
        return (a == OFS_DATA) || (a == OFS_DIR) || (a == OFS_OPT) ||
               (a == OFS_SENS) || (a == OFS_CTRL) || (a == OFS_PEND);
    endfunction : addr_mapped

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    // two-stage synchroniser
    always_ff @(posedge clk) begin
        sync1_q <= pin_in;
        sync2_q <= sync1_q;
    end

    // ----------------------------------------------------------------
    // Pin configuration decode
    // ----------------------------------------------------------------
    // peripheral forces output
    wire [NPINS-1:0] dir_eff = pin_direction_bit_q | alt_out_en;
    wire [NPINS-1:0] drive_val = (alt_out_en & alt_out_val) | (~alt_out_en & pin_data_latch_q);
    wire [NPINS-1:0] push_pull = dir_eff & pin_option_bit_q;
    wire [NPINS-1:0] oe_b_d = ~dir_eff | (~push_pull & drive_val);
    wire [NPINS-1:0] pull_d = ~dir_eff & pin_option_bit_q;
    wire [NPINS-1:0] hi_d = push_pull & drive_val;
    wire [NPINS-1:0] alt_in_d = (pin_direction_bit_q & pin_data_latch_q) |
                                (~pin_direction_bit_q & sync2_q);
    wire [NPINS-1:0] in_rd = (alt_out_en & alt_out_val) | (~alt_out_en & sync2_q);
    wire [NPINS-1:0] data_rd = (pin_direction_bit_q & pin_data_latch_q) |
                               (~pin_direction_bit_q & in_rd);

    // floating input reaches peripheral; per-bit port
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_out_q <= ALL_ZERO;
            pin_oe_b_q <= ALL_ONES;
            pull_up_q <= ALL_ZERO;
            high_drive_q <= ALL_ZERO;
            alt_in_q <= ALL_ZERO;
        end else begin
            pin_out_q <= drive_val;
            pin_oe_b_q <= oe_b_d;
            pull_up_q <= pull_d;
            high_drive_q <= hi_d;
            alt_in_q <= alt_in_d;
        end
    end

    // ----------------------------------------------------------------
    // External interrupt
    // ----------------------------------------------------------------
    // interrupt input on input plus option
    wire [NPINS-1:0] irq_pin_en = ~pin_direction_bit_q & pin_option_bit_q;
    wire [NPINS-1:0] det_in = sync2_q | ~irq_pin_en;
    logic [NVEC-1:0] src_lvl, edge_hit, sens_chg;
    logic do_write;
    logic [AW-1:0] wr_addr;
    always_comb begin
        for (int v = 0; v < NVEC; v++) begin
            src_lvl[v] = group_level(det_in, v);
        end
    end
    assign edge_hit = (ext_irq_sensitivity_ctrl_q & src_lvl & ~src_prev_q) |
                      (~ext_irq_sensitivity_ctrl_q & ~src_lvl & src_prev_q);
    assign sens_chg = ext_irq_sensitivity_ctrl_d ^ ext_irq_sensitivity_ctrl_q;
    // fetch clears; sensitivity change clears; a new edge wins
    assign pend_d = edge_hit | (pend_q & ~vector_fetch & ~sens_chg);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            src_prev_q <= {NVEC{1'b1}};
            pend_q <= {NVEC{1'b0}};
            irq_req_q <= {NVEC{1'b0}};
            wake_q <= 1'b0;
        end else begin
            src_prev_q <= src_lvl;
            pend_q <= pend_d;
            irq_req_q <= pend_q & {NVEC{~gmask_q}};
            wake_q <= |pend_q;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    wire aw_take = s_axi_awvalid && awready_q;
    wire w_take = s_axi_wvalid && wready_q;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    assign wr_addr = aw_addr_q;
    wire wr_lane0 = do_write && wstrb_q[0];
    wire ar_take = s_axi_arvalid && arready_q;
    wire [7:0] wbyte = wdata_q[7:0];

    assign pin_data_latch_d = (wr_lane0 && wr_addr == OFS_DATA) ? wbyte : pin_data_latch_q;
    assign pin_direction_bit_d = (wr_lane0 && wr_addr == OFS_DIR) ? wbyte : pin_direction_bit_q;
    assign pin_option_bit_d = (wr_lane0 && wr_addr == OFS_OPT) ? wbyte : pin_option_bit_q;
    assign ext_irq_sensitivity_ctrl_d = (wr_lane0 && wr_addr == OFS_SENS) ?
                                        wbyte[NVEC-1:0] : ext_irq_sensitivity_ctrl_q;
    assign gmask_d = (wr_lane0 && wr_addr == OFS_CTRL) ? wbyte[CTRL_GMASK] : gmask_q;

    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (ar_addr_q)
            OFS_DATA: rd_word[NPINS-1:0] = data_rd;
            OFS_DIR: rd_word[NPINS-1:0] = pin_direction_bit_q;
            OFS_OPT: rd_word[NPINS-1:0] = pin_option_bit_q;
            OFS_SENS: rd_word[NVEC-1:0] = ext_irq_sensitivity_ctrl_q;
            OFS_CTRL: rd_word[CTRL_GMASK] = gmask_q;
            OFS_PEND: rd_word[NVEC-1:0] = pend_q;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_data_latch_q <= RST_DATA;
            pin_direction_bit_q <= RST_DIR;
            pin_option_bit_q <= RST_OPT;
            ext_irq_sensitivity_ctrl_q <= RST_SENS;
            gmask_q <= RST_GMASK;
        end else begin
            pin_data_latch_q <= pin_data_latch_d;
            pin_direction_bit_q <= pin_direction_bit_d;
            pin_option_bit_q <= pin_option_bit_d;
            ext_irq_sensitivity_ctrl_q <= ext_irq_sensitivity_ctrl_d;
            gmask_q <= gmask_d;
        end
    end

    // Address and data are latched separately so either may come first.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            aw_addr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= addr_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read data is captured one cycle after the address so pin reads stay coherent.
    logic rd_pend_q;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_pend_q <= 1'b0;
            rvalid_q <= 1'b0;
            ar_addr_q <= '0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else begin
            if (ar_take && !rd_pend_q) begin
                rd_pend_q <= 1'b1;
                ar_addr_q <= s_axi_araddr;
            end
            if (rd_pend_q) begin
                rd_pend_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rd_word;
                rresp_q <= addr_mapped(ar_addr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
        end else begin
            awready_q <= !aw_held_q && !aw_take && !do_write && !bvalid_q;
            wready_q <= !w_held_q && !w_take && !do_write && !bvalid_q;
            arready_q <= !rvalid_q && !rd_pend_q && !(s_axi_arvalid && arready_q);
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign pin_out = pin_out_q;
    assign pin_oe_b = pin_oe_b_q;
    assign pull_up_en = pull_up_q;
    assign high_drive_en = high_drive_q;
    assign alt_in = alt_in_q;
    assign irq_req = irq_req_q;
    assign wake_req = wake_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire [NPINS-1:0] alt_low = alt_out_en & ~alt_out_val;
    wire [NPINS-1:0] od_high = pin_direction_bit_q & ~pin_option_bit_q &
                               pin_data_latch_q & ~alt_out_en;

    a_input_floats: assert property ((pin_direction_bit_q == ALL_ZERO && alt_out_en == ALL_ZERO)
        |=> pin_oe_b_q == ALL_ONES) else $error("input pin driven");
    a_od_one_float: assert property (1'b1 |=> (($past(od_high) & ~pin_oe_b_q) == ALL_ZERO))
        else $error("open-drain one driven");
    a_alt_low_drives: assert property (1'b1 |=> (($past(alt_low) & pin_oe_b_q) == ALL_ZERO))
        else $error("peripheral low not driven");
    a_pullup_cfg: assert property (1'b1 |=> pull_up_q == ($past(pull_d)) &&
        (pull_up_q & high_drive_q) == ALL_ZERO) else $error("pull-up wrong");
    a_fetch_clears: assert property ((pend_q[0] && vector_fetch[0] && !edge_hit[0])
        |=> !pend_q[0]) else $error("fetch left pending");
    a_sens_clears: assert property ((sens_chg[1] && !edge_hit[1]) |=> !pend_q[1])
        else $error("sensitivity change left pending");
    a_mask_blocks: assert property (gmask_q[*2] |=> irq_req_q == {NVEC{1'b0}})
        else $error("masked request seen");
    a_rise_sets: assert property ((ext_irq_sensitivity_ctrl_q[0] && src_lvl[0] &&
        !src_prev_q[0]) |=> pend_q[0]) else $error("rising edge missed");
    a_disabled_high: assert property ((irq_pin_en == ALL_ZERO)[*2] |-> !edge_hit[0] &&
        !edge_hit[1]) else $error("disabled pins made edge");
    a_read_answer: assert property (rd_pend_q |=> rvalid_q)
        else $error("read answer late");
    a_out_read_latch: assert property (
        (rd_pend_q && ar_addr_q == OFS_DATA && pin_direction_bit_q == ALL_ONES)
        |=> rdata_q[NPINS-1:0] == $past(pin_data_latch_q))
        else $error("output read not latch");
    a_alt_in_latch: assert property (
        1'b1 |=> ((alt_in_q ^ $past(pin_data_latch_q)) & $past(pin_direction_bit_q)) == ALL_ZERO)
        else $error("peripheral input not latch");
    a_wake_pending: assert property (
        1'b1 |=> wake_q == (|$past(pend_q))) else $error("wake not pending");
    c_write: cover property (do_write);
    c_read_data: cover property (rvalid_q && ar_addr_q == OFS_DATA);
    c_irq: cover property (irq_req_q[0]);
    c_sens_clear: cover property (pend_q[1] && sens_chg[1]);
    c_fetch_clear: cover property (pend_q[0] && vector_fetch[0]);
endmodule : gpx_port

// ===== tb/gpx_pin_model.sv
// Purpose: Pad model that resolves the level seen on each port pin.
// Assumes: Port drive wins over the external driver; bench sets the external side.
// Notes:   An undriven pad without pull-up toggles each cycle, never a stable level.
module gpx_pin_model (
    input wire logic clk,
    input wire logic [gpx_pkg::NPINS-1:0] pin_out,
    input wire logic [gpx_pkg::NPINS-1:0] pin_oe_b,
    input wire logic [gpx_pkg::NPINS-1:0] pull_up_en,
    input wire logic [gpx_pkg::NPINS-1:0] ext_en,
    input wire logic [gpx_pkg::NPINS-1:0] ext_val,
    output logic [gpx_pkg::NPINS-1:0] pin_lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    import gpx_pkg::*;
    logic [NPINS-1:0] flt_q = 8'h55;
    always @(posedge clk) begin
        flt_q <= ~flt_q;
    end
    assign pin_lvl = (~pin_oe_b & pin_out) | (pin_oe_b & ext_en & ext_val)
        | (pin_oe_b & ~ext_en & (pull_up_en | flt_q));
endmodule : gpx_pin_model

// ===== tb/gpx_port_tb.sv
// Purpose: Self-checking bench for the I/O port over AXI4-Lite.
// Assumes: Pin model gives pad levels; bench drives peripheral and fetch inputs.
// Notes:   Bus task waits are unbounded; a watchdog ends a hang.
`define CHK(nm, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
        end \
    end
module gpx_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import gpx_pkg::*;
    int fails = 0;
    int samples_checked = 0;
    logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
    logic [AW-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid, wake;
    logic [1:0] bresp, rresp, irq, fetch;
    logic [NPINS-1:0] pin_lvl, pout, oe_b, pull, hdrv, aoe, aval, ain, ext_en, ext_val;
    // ------------------------------------------------------------
    // Design and pad model
    // ------------------------------------------------------------
    gpx_port dut_u (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pin_in(pin_lvl), .pin_out(pout), .pin_oe_b(oe_b), .pull_up_en(pull),
        .high_drive_en(hdrv), .alt_out_en(aoe), .alt_out_val(aval), .alt_in(ain),
        .vector_fetch(fetch), .irq_req(irq), .wake_req(wake));
    gpx_pin_model pin_u (.clk(clk), .pin_out(pout), .pin_oe_b(oe_b), .pull_up_en(pull),
        .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // Waits are unbounded here; the watchdog ends a hang.
    task automatic wr(input logic [AW-1:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw, w;
        logic [1:0] r;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw | w) begin
            @(posedge clk);
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) begin
            @(posedge clk);
        end
        r = bresp;
        bready <= 1'b0;
        `CHK("bresp", er, r)
        @(posedge clk);
    endtask : wr
    task automatic rd(input string nm, input logic [AW-1:0] a, input logic [7:0] ex,
                      input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        do begin
            @(posedge clk);
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        `CHK(nm, {24'h0, ex}, d)
        `CHK("rresp", er, r)
        @(posedge clk);
    endtask : rd
    task automatic done(input string t);
        $display("test %s finished", t);
    endtask : done
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        report_and_stop();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {rst_b, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = '0;
        {wdata, wstrb, aoe, aval, fetch} = {32'h0, 4'hf, 8'h00, 8'h00, 2'h0};
        ext_en = 8'hff;
        ext_val = 8'h5a;
        tick(2);
        rst_b <= 1'b1;
        @(posedge clk);
        rd("dir", OFS_DIR, RST_DIR, RESP_OKAY);
        rd("opt", OFS_OPT, RST_OPT, RESP_OKAY);
        rd("ctrl", OFS_CTRL, 8'h01, RESP_OKAY);
        rd("unmapped", 8'h20, 8'h00, RESP_SLVERR);
        wr(8'h20, 8'hff, RESP_SLVERR);
        wr(OFS_PEND, 8'hff, RESP_OKAY);
        rd("pend", OFS_PEND, 8'h00, RESP_OKAY);
        done("reset");
        rd("in data", OFS_DATA, 8'h5a, RESP_OKAY);
        // alternate input kept floating, no interrupt
        `CHK("alt_in float", 8'h5a, ain)
        wr(OFS_DATA, 8'hff, RESP_OKAY);
        tick(3);
        `CHK("oe input", 8'hff, oe_b)
        aoe <= 8'h03;
        aval <= 8'h01;
        tick(4);
        rd("alt read", OFS_DATA, 8'h59, RESP_OKAY);
        // Option is 0, so the peripheral's one on pin 0 floats as open-drain
        `CHK("alt oe", 8'h01, oe_b & 8'h03)
        `CHK("alt out", 8'h01, pout & 8'h03)
        aoe <= 8'h00;
        done("input");
        wr(OFS_DIR, 8'hff, RESP_OKAY);
        wr(OFS_OPT, 8'h0f, RESP_OKAY);
        wr(OFS_DATA, 8'ha5, RESP_OKAY);
        tick(3);
        `CHK("oe out", 8'ha0, oe_b)
        `CHK("pin_out", 8'h05, pout & 8'h5f)
        `CHK("high drv", 8'h05, hdrv)
        `CHK("pull out", 8'h00, pull)
        `CHK("alt_in out", 8'ha5, ain)
        rd("out data", OFS_DATA, 8'ha5, RESP_OKAY);
        wr(OFS_DIR, 8'h00, RESP_OKAY);
        wr(OFS_OPT, 8'hf0, RESP_OKAY);
        tick(3);
        `CHK("pull in", 8'hf0, pull)
        `CHK("high in", 8'h00, hdrv)
        done("output");
        ext_val <= 8'hff;
        wr(OFS_CTRL, 8'h01, RESP_OKAY);
        wr(OFS_SENS, 8'h03, RESP_OKAY);
        wr(OFS_OPT, 8'hff, RESP_OKAY);
        wr(OFS_SENS, 8'h02, RESP_OKAY);
        wr(OFS_CTRL, 8'h00, RESP_OKAY);
        rd("pend idle", OFS_PEND, 8'h00, RESP_OKAY);
        ext_val <= 8'hdd;
        tick(6);
        `CHK("irq fall", 2'h1, irq)
        rd("pend fall", OFS_PEND, 8'h01, RESP_OKAY);
        ext_val <= 8'hff;
        tick(6);
        rd("pend rise", OFS_PEND, 8'h03, RESP_OKAY);
        `CHK("irq both", 2'h3, irq)
        fetch <= 2'h3;
        @(posedge clk);
        fetch <= 2'h0;
        tick(3);
        `CHK("irq fetched", 2'h0, irq)
        rd("pend fetched", OFS_PEND, 8'h00, RESP_OKAY);
        ext_val <= 8'hfd;
        tick(6);
        fetch <= 2'h1;
        @(posedge clk);
        fetch <= 2'h0;
        ext_val <= 8'hf9;
        tick(6);
        rd("pend grouped", OFS_PEND, 8'h00, RESP_OKAY);
        ext_val <= 8'hff;
        tick(6);
        ext_val <= 8'hfe;
        tick(6);
        rd("pend set", OFS_PEND, 8'h01, RESP_OKAY);
        wr(OFS_SENS, 8'h03, RESP_OKAY);
        rd("pend sens", OFS_PEND, 8'h00, RESP_OKAY);
        wr(OFS_OPT, 8'hfe, RESP_OKAY);
        tick(4);
        rd("pend spur", OFS_PEND, 8'h01, RESP_OKAY);
        wr(OFS_CTRL, 8'h01, RESP_OKAY);
        tick(3);
        `CHK("irq masked", 2'h0, irq)
        `CHK("wake", 1'b1, wake)
        wr(OFS_SENS, 8'h02, RESP_OKAY);
        wr(OFS_OPT, 8'h00, RESP_OKAY);
        wr(OFS_SENS, 8'h03, RESP_OKAY);
        wr(OFS_CTRL, 8'h00, RESP_OKAY);
        tick(4);
        rd("pend off", OFS_PEND, 8'h00, RESP_OKAY);
        `CHK("irq off", 2'h0, irq)
        done("interrupt");
        report_and_stop();
    end
endmodule : gpx_port_tb
